//--- rtl/reset_seq_consts.vh
// timing, register map and encodings of the reset time-out sequencer
`ifndef RESET_SEQ_CONSTS_VH
`define RESET_SEQ_CONSTS_VH

`define CLK_NS         10
`define RC_PERIOD_NS   1000
`define RC_DIV_CYC     (`RC_PERIOD_NS / `CLK_NS)
`define POWER_UP_TIMER_MS        72
`define POWER_UP_TIMER_TICKS     (`POWER_UP_TIMER_MS * 1000000 / `RC_PERIOD_NS)
`define PLL_MS         2
`define PLL_TICKS      (`PLL_MS * 1000000 / `RC_PERIOD_NS)
`define OST_CYCLES     1024
// 1.5 us wake recovery, held in ns
`define EC_WAKE_NS     1500
`define EC_WAKE_CYC    ((`EC_WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`define MASTER_CLEAR_PIN_FILT_CYC  4
`define TMR_W          24

`define REG_CONFIG     12'h000
`define REG_STATUS     12'h004
`define REG_CAUSE      12'h008

`define CFG_POWER_UP_TIMER_EN    0
`define CFG_BOR_EN     1
`define CFG_MODE_LSB   2
`define CFG_MODE_MSB   4
`define CFG_RESET      5'h0b

`define FLG_BOR        0
`define FLG_POR        1
`define FLG_PD         2
`define FLG_TO         3
`define FLG_RI         4
`define FLAGS_RESET    5'h1c

`define MODE_LP        3'h0
`define MODE_XT        3'h1
`define MODE_HS        3'h2
`define MODE_HS_PLL    3'h3
`define MODE_EC        3'h4
`define MODE_EC_PLL    3'h5
`define MODE_RC        3'h6

`define CAUSE_POR      3'h0
`define CAUSE_PIN      3'h1
`define CAUSE_PIN_SLP  3'h2
`define CAUSE_WDT      3'h3
`define CAUSE_BOR      3'h4
`define CAUSE_INSTR    3'h5
`define CAUSE_STK_FULL 3'h6
`define CAUSE_STK_UNDR 3'h7

`define RESET_VECTOR   16'h0000

`endif

//--- rtl/pin_noise_filter.v
// noise filter that accepts a pin level only after it stays stable
`timescale 1ns/1ps

module pin_noise_filter #(
  parameter integer FILT_CYCLES = 4,
  parameter integer CNT_W       = 8
) (
  input  wire core_clk,
  input  wire srst,
  input  wire pin_in,
  output reg  pin_filt
);

  localparam [CNT_W-1:0] LIM = FILT_CYCLES[CNT_W-1:0] - 8'h01;

  reg [CNT_W-1:0] stable_cnt_reg;

  // short pulses restart the count and never reach the output
  always @(posedge core_clk) begin
    if (srst) begin
      pin_filt       <= 1'b1;
      stable_cnt_reg <= {CNT_W{1'b0}};
    end else if (pin_in == pin_filt) begin
      stable_cnt_reg <= {CNT_W{1'b0}};
    end else if (stable_cnt_reg == LIM) begin
      pin_filt       <= pin_in;
      stable_cnt_reg <= {CNT_W{1'b0}};
    end else begin
      stable_cnt_reg <= stable_cnt_reg + 8'h01;
    end
  end

endmodule // pin_noise_filter

//--- rtl/reset_timeout_sequencer.v
// reset source collector and power-up time-out sequencer with apb access
`timescale 1ns/1ps
`include "reset_seq_consts.vh"

module reset_timeout_sequencer #(
  parameter integer RC_DIV      = `RC_DIV_CYC,
  parameter integer POWER_UP_TIMER_TICKS  = `POWER_UP_TIMER_TICKS,
  parameter integer PLL_TICKS   = `PLL_TICKS,
  parameter integer OST_CYCLES  = `OST_CYCLES,
  parameter integer FILT_CYCLES = `MASTER_CLEAR_PIN_FILT_CYC
) (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        por_pulse,
  input  wire        brownout_detect,
  input  wire        master_clear_pin_n,
  input  wire        osc_input_pin,
  input  wire        sleep_mode,
  input  wire        watchdog_reset,
  input  wire        watchdog_wake,
  input  wire        int_wake,
  input  wire        reset_instr,
  input  wire        stack_full_reset,
  input  wire        stack_underflow_reset,
  output reg         core_reset_hold,
  output reg         core_wake_stall,
  output reg         core_restart,
  output reg         sfr_init,
  output reg         power_on_init,
  output reg  [15:0] reset_vector
);

  localparam TW = `TMR_W;
  localparam [2:0] ST_RUN  = 3'h0;
  localparam [2:0] ST_POR  = 3'h1;
  localparam [2:0] ST_BOR  = 3'h2;
  localparam [2:0] ST_POWER_UP_TIMER = 3'h3;
  localparam [2:0] ST_OST  = 3'h4;
  localparam [2:0] ST_PLL  = 3'h5;
  localparam [2:0] ST_WREC = 3'h6;

  localparam [TW-1:0] POWER_UP_TIMER_LIM = POWER_UP_TIMER_TICKS[TW-1:0];
  localparam [TW-1:0] PLL_LIM  = PLL_TICKS[TW-1:0];
  localparam [TW-1:0] OST_LIM  = OST_CYCLES[TW-1:0];
  localparam integer  WREC_CYC = `EC_WAKE_CYC;
  localparam [TW-1:0] WREC_LIM = WREC_CYC[TW-1:0];
  localparam [TW-1:0] RC_LIM   = RC_DIV[TW-1:0];

  function reached;
    input [TW-1:0] cnt;
    input [TW-1:0] lim;
    begin
      reached = (cnt + 24'h000001 >= lim);
    end
  endfunction

  function is_crystal;
    input [2:0] mode;
    begin
      is_crystal = (mode == `MODE_LP) || (mode == `MODE_XT) ||
                   (mode == `MODE_HS) || (mode == `MODE_HS_PLL);
    end
  endfunction

  function is_pll;
    input [2:0] mode;
    begin
      is_pll = (mode == `MODE_HS_PLL) || (mode == `MODE_EC_PLL);
    end
  endfunction

  // step after the power-up timer; oscillator count only on por or wake
  function [2:0] after_power_up_timer;
    input [2:0] mode;
    input       osc_ok;
    begin
      if (osc_ok && is_crystal(mode))
        after_power_up_timer = ST_OST;
      else if (osc_ok && is_pll(mode))
        after_power_up_timer = ST_PLL;
      else
        after_power_up_timer = ST_RUN;
    end
  endfunction

  reg [4:0]    cfg_reg;
  reg [4:0]    flags_reg;
  reg [2:0]    cause_reg;
  reg [2:0]    state_reg;
  reg [2:0]    state_next;
  reg [TW-1:0] cnt_reg;
  reg [TW-1:0] cnt_next;
  reg [TW-1:0] rc_div_reg;
  reg          rc_tick_reg;
  reg          wake_reg;
  reg          wake_next;
  reg          por_seq_reg;
  reg          por_seq_next;
  reg          osc_prev_reg;
  reg          por_prev_reg;
  reg          bor_prev_reg;
  reg          master_clear_pin_prev_reg;
  reg          step;
  reg          hold_next;
  reg          stall_next;
  reg          rst_event;
  reg [2:0]    ev_cause;
  reg [4:0]    flags_next;

  wire       master_clear_pin_filt;
  wire [2:0] mode      = cfg_reg[`CFG_MODE_MSB:`CFG_MODE_LSB];
  wire       power_up_timer_en   = cfg_reg[`CFG_POWER_UP_TIMER_EN];
  wire       bor_act   = brownout_detect & cfg_reg[`CFG_BOR_EN];
  wire       master_clear_pin_act  = ~master_clear_pin_filt;
  wire       por_rise  = por_pulse & ~por_prev_reg;
  wire       bor_rise  = bor_act & ~bor_prev_reg;
  wire       master_clear_pin_fall = master_clear_pin_act & ~master_clear_pin_prev_reg;
  wire       osc_rise  = osc_input_pin & ~osc_prev_reg;
  wire       wake_ev   = (watchdog_wake | int_wake) & sleep_mode;
  wire       wr_en     = psel & penable & pwrite & pready;

  // pin is only ever sampled here; no path drives it back
  pin_noise_filter #(
    .FILT_CYCLES (FILT_CYCLES),
    .CNT_W       (8)
  ) u_master_clear_pin_filt (
    .core_clk (core_clk),
    .srst     (srst),
    .pin_in   (master_clear_pin_n),
    .pin_filt (master_clear_pin_filt)
  );

  // internal rc time base, free of the main oscillator
  always @(posedge core_clk) begin
    if (srst) begin
      rc_div_reg  <= {TW{1'b0}};
      rc_tick_reg <= 1'b0;
    end else if (reached(rc_div_reg, RC_LIM)) begin
      rc_div_reg  <= {TW{1'b0}};
      rc_tick_reg <= 1'b1;
    end else begin
      rc_div_reg  <= rc_div_reg + 24'h000001;
      rc_tick_reg <= 1'b0;
    end
  end

  // sequencer next state; the pin level never stops the timers
  always @* begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    wake_next    = wake_reg;
    por_seq_next = por_seq_reg;
    step         = 1'b0;
    if (por_pulse) begin
      state_next   = ST_POR;
      cnt_next     = {TW{1'b0}};
      wake_next    = 1'b0;
      por_seq_next = 1'b1;
    end else if (bor_act) begin
      // recurring brown-out wipes a running timer
      state_next   = ST_BOR;
      cnt_next     = {TW{1'b0}};
      wake_next    = 1'b0;
      por_seq_next = 1'b0;
    end else if ((wake_ev || (master_clear_pin_fall && sleep_mode)) &&
                 (state_reg == ST_RUN)) begin
      cnt_next  = {TW{1'b0}};
      wake_next = 1'b1;
      if (is_crystal(mode))
        state_next = ST_OST;
      else if (mode == `MODE_EC_PLL)
        state_next = ST_PLL;
      else if (mode == `MODE_EC)
        state_next = ST_WREC;
      else
        state_next = ST_RUN;
    end else begin
      case (state_reg)
        ST_RUN: begin
          wake_next = 1'b0;
        end
        ST_POR: begin
          // rc mode with timer off falls straight through
          state_next = power_up_timer_en ? ST_POWER_UP_TIMER : after_power_up_timer(mode, 1'b1);
        end
        ST_BOR: begin
          state_next = power_up_timer_en ? ST_POWER_UP_TIMER : ST_RUN;
        end
        ST_POWER_UP_TIMER: begin
          step = rc_tick_reg;
          if (step && reached(cnt_reg, POWER_UP_TIMER_LIM)) begin
            state_next = after_power_up_timer(mode, por_seq_reg);
            cnt_next   = {TW{1'b0}};
          end
        end
        ST_OST: begin
          step = osc_rise;
          if (step && reached(cnt_reg, OST_LIM)) begin
            state_next = is_pll(mode) ? ST_PLL : ST_RUN;
            cnt_next   = {TW{1'b0}};
          end
        end
        ST_PLL: begin
          step = rc_tick_reg;
          if (step && reached(cnt_reg, PLL_LIM)) begin
            state_next = ST_RUN;
            cnt_next   = {TW{1'b0}};
          end
        end
        ST_WREC: begin
          step = 1'b1;
          if (reached(cnt_reg, WREC_LIM)) begin
            state_next = ST_RUN;
            cnt_next   = {TW{1'b0}};
          end
        end
        default: begin
          state_next = ST_POR;
          cnt_next   = {TW{1'b0}};
        end
      endcase
      if (step && state_next == state_reg)
        cnt_next = cnt_reg + 24'h000001;
    end
  end

  // reset event decode and cause flags; highest source first
  always @* begin
    rst_event  = 1'b1;
    ev_cause   = `CAUSE_POR;
    flags_next = flags_reg;
    if (wr_en && paddr == `REG_STATUS)
      flags_next = pwdata[4:0];
    // hardware updates land after the software write, so they win
    if (por_rise) begin
      ev_cause   = `CAUSE_POR;
      flags_next = 5'h1c;
    end else if (bor_rise) begin
      ev_cause   = `CAUSE_BOR;
      flags_next = 5'h1e;
    end else if (master_clear_pin_fall && sleep_mode) begin
      ev_cause = `CAUSE_PIN_SLP;
      flags_next[`FLG_TO] = 1'b1;
      flags_next[`FLG_PD] = 1'b0;
    end else if (master_clear_pin_fall) begin
      ev_cause = `CAUSE_PIN;
    end else if (watchdog_reset) begin
      ev_cause = `CAUSE_WDT;
      flags_next[`FLG_RI] = 1'b1;
      flags_next[`FLG_TO] = 1'b0;
      flags_next[`FLG_PD] = 1'b1;
    end else if (reset_instr) begin
      ev_cause = `CAUSE_INSTR;
      flags_next[`FLG_RI] = 1'b0;
    end else if (stack_full_reset) begin
      ev_cause = `CAUSE_STK_FULL;
    end else if (stack_underflow_reset) begin
      ev_cause = `CAUSE_STK_UNDR;
    end else begin
      rst_event = 1'b0;
      if (wake_ev) begin
        // wake-up is resumption: flags only, no init
        flags_next[`FLG_TO] = ~watchdog_wake;
        flags_next[`FLG_PD] = 1'b0;
      end
    end
  end

  // one merged hold: timers, pin, pulsed sources
  always @* begin
    hold_next  = ((state_next != ST_RUN) && !wake_next) || master_clear_pin_act ||
                 (rst_event && !(ev_cause == `CAUSE_PIN_SLP));
    stall_next = (state_next != ST_RUN) && wake_next && !hold_next;
  end

  always @(posedge core_clk) begin
    if (srst) begin
      state_reg       <= ST_POR;
      cnt_reg         <= {TW{1'b0}};
      wake_reg        <= 1'b0;
      por_seq_reg     <= 1'b1;
      osc_prev_reg    <= 1'b0;
      por_prev_reg    <= 1'b0;
      bor_prev_reg    <= 1'b0;
      master_clear_pin_prev_reg   <= 1'b0;
      flags_reg       <= `FLAGS_RESET;
      cause_reg       <= `CAUSE_POR;
      core_reset_hold <= 1'b1;
      core_wake_stall <= 1'b0;
      core_restart    <= 1'b0;
      sfr_init        <= 1'b0;
      power_on_init   <= 1'b0;
      reset_vector    <= `RESET_VECTOR;
    end else begin
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      wake_reg        <= wake_next;
      por_seq_reg     <= por_seq_next;
      osc_prev_reg    <= osc_input_pin;
      por_prev_reg    <= por_pulse;
      bor_prev_reg    <= bor_act;
      master_clear_pin_prev_reg   <= master_clear_pin_act;
      flags_reg       <= flags_next;
      if (rst_event)
        cause_reg <= ev_cause;
      core_reset_hold <= hold_next;
      core_wake_stall <= stall_next;
      // restart from the fixed vector on leaving reset
      core_restart    <= core_reset_hold & ~hold_next;
      reset_vector    <= `RESET_VECTOR;
      // stack resets also reload the designated registers
      sfr_init        <= rst_event;
      // ordinary registers are only scrambled at power-on
      power_on_init   <= por_rise;
    end
  end

  // apb slave: data prepared in setup, answered in the first access cycle
  always @(posedge core_clk) begin
    if (srst) begin
      cfg_reg <= `CFG_RESET;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (wr_en && paddr == `REG_CONFIG)
        cfg_reg <= pwdata[4:0];
      if (psel && !penable) begin
        pready  <= 1'b1;
        pslverr <= 1'b0;
        case (paddr)
          `REG_CONFIG: prdata <= {27'h0000000, cfg_reg};
          `REG_STATUS: prdata <= {27'h0000000, flags_reg};
          `REG_CAUSE:  prdata <= {21'h000000, cnt_reg[TW-1:TW-4],
                                  state_reg, 1'b0, cause_reg};
          default: begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
      end
    end
  end

endmodule // reset_timeout_sequencer

//--- dv/seq_monitor.sv
// port assertions for the reset time-out sequencer
`timescale 1ns/1ps
`include "reset_seq_consts.vh"
module seq_monitor #(
  parameter integer RC_DIV     = 2,
  parameter integer POWER_UP_TIMER_TICKS = 20
) (
  input wire        core_clk,
  input wire        srst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        por_pulse,
  input wire        brownout_detect,
  input wire        master_clear_pin_n,
  input wire        sleep_mode,
  input wire        int_wake,
  input wire        watchdog_reset,
  input wire        reset_instr,
  input wire        stack_full_reset,
  input wire        stack_underflow_reset,
  input wire        core_reset_hold,
  input wire        core_wake_stall,
  input wire        core_restart,
  input wire        power_on_init
);
  localparam int PW_LO = POWER_UP_TIMER_TICKS * RC_DIV - 3;
  reg [4:0] cfg_q;
  // shadow of the config word, needed to qualify mode-dependent checks
  always @(posedge core_clk) begin
    if (srst)
      cfg_q <= `CFG_RESET;
    else if (psel && penable && pready && pwrite && paddr == `REG_CONFIG)
      cfg_q <= pwdata[4:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_por_holds: assert property (por_pulse |=> core_reset_hold)
    else $error("hold missing during power-on");
  a_por_init: assert property ($rose(por_pulse) |=> power_on_init)
    else $error("no power-on init pulse");
  a_bor_holds: assert property (brownout_detect && cfg_q[1]
    |=> core_reset_hold)
    else $error("hold missing during brown-out");
  a_src_holds: assert property ((watchdog_reset || reset_instr ||
    stack_full_reset || stack_underflow_reset) |=> core_reset_hold)
    else $error("internal source did not hold core");
  a_pin_holds: assert property (!master_clear_pin_n [*8]
    |-> core_reset_hold)
    else $error("long pin low did not hold core");
  a_rc_fast: assert property ($fell(por_pulse) && cfg_q[4:2] == `MODE_RC &&
    !cfg_q[0] && master_clear_pin_n && !brownout_detect
    |-> ##[1:2] !core_reset_hold)
    else $error("rc mode without timer still delayed");
  a_power_up_timer_span: assert property ($fell(por_pulse) && cfg_q[4:2] == `MODE_RC &&
    cfg_q[0] && master_clear_pin_n && !brownout_detect
    |-> ##PW_LO core_reset_hold ##[1:8] !core_reset_hold)
    else $error("power-up timer span wrong");
  a_restart: assert property ($fell(core_reset_hold)
    |-> ##[0:1] core_restart)
    else $error("no restart pulse after release");
  a_ec_wake: assert property (int_wake && sleep_mode && !core_reset_hold &&
    !core_wake_stall && cfg_q[4:2] == `MODE_EC
    |-> ##140 core_wake_stall ##[1:20] !core_wake_stall)
    else $error("external clock wake recovery wrong");
endmodule // seq_monitor
bind reset_timeout_sequencer seq_monitor #(
  .RC_DIV(RC_DIV), .POWER_UP_TIMER_TICKS(POWER_UP_TIMER_TICKS)) seq_monitor_i (
  .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .por_pulse(por_pulse), .brownout_detect(brownout_detect),
  .master_clear_pin_n(master_clear_pin_n), .sleep_mode(sleep_mode),
  .int_wake(int_wake), .watchdog_reset(watchdog_reset),
  .reset_instr(reset_instr), .stack_full_reset(stack_full_reset),
  .stack_underflow_reset(stack_underflow_reset),
  .core_reset_hold(core_reset_hold), .core_wake_stall(core_wake_stall),
  .core_restart(core_restart), .power_on_init(power_on_init));

//--- dv/supply_model.sv
// supply monitors, reset pin and crystal seen from outside the block
`timescale 1ns/1ps
module supply_model (
  input wire core_clk,
  output reg por_pulse,
  output reg brownout_detect,
  output reg master_clear_pin_n,
  output reg osc_input_pin
);
  reg [1:0] div_reg;
  initial begin
    por_pulse = 1'b0;
    brownout_detect = 1'b0;
    master_clear_pin_n = 1'b1;
    osc_input_pin = 1'b0;
    div_reg = 2'h0;
  end
  // oscillator at a sixth of the core rate, free running
  always @(posedge core_clk) begin
    div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
    if (div_reg == 2'h2)
      osc_input_pin <= ~osc_input_pin;
  end
  // automatic so the pin and supply may be driven at once
  task automatic drive(input integer s, input integer n);
    begin
      if (s == 0) por_pulse <= 1'b1;
      else if (s == 1) brownout_detect <= 1'b1;
      else master_clear_pin_n <= 1'b0;
      repeat (n) @(posedge core_clk);
      if (s == 0) por_pulse <= 1'b0;
      else if (s == 1) brownout_detect <= 1'b0;
      else master_clear_pin_n <= 1'b1; // pull-up restores high
    end
  endtask
endmodule // supply_model

//--- dv/tb_top.sv
// self-checking bench for the reset time-out sequencer
`timescale 1ns/1ps
`include "reset_seq_consts.vh"
module tb_top;
  localparam integer RCD = 2, PWT = 20, PLT = 5, OSTC = 8, OSP = 6;
  reg         core_clk, srst, psel, penable, pwrite, sleep_mode, err, p;
  reg         watchdog_reset, watchdog_wake, int_wake, reset_instr;
  reg         stack_full_reset, stack_underflow_reset, hs;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [2:0]  m;
  wire [31:0] prdata;
  wire        pready, pslverr, por_pulse, brownout_detect;
  wire        master_clear_pin_n, osc_input_pin, core_reset_hold;
  wire        core_wake_stall, core_restart, sfr_init, power_on_init;
  wire [15:0] reset_vector;
  integer     bad_count, comparisons, i, n, e, sfr_n, s0;
  reset_timeout_sequencer #(.RC_DIV(RCD), .POWER_UP_TIMER_TICKS(PWT),
    .PLL_TICKS(PLT), .OST_CYCLES(OSTC), .FILT_CYCLES(4))
    reset_timeout_sequencer_i (.core_clk(core_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_pulse(por_pulse), .brownout_detect(brownout_detect),
    .master_clear_pin_n(master_clear_pin_n), .osc_input_pin(osc_input_pin),
    .sleep_mode(sleep_mode), .watchdog_reset(watchdog_reset),
    .watchdog_wake(watchdog_wake), .int_wake(int_wake),
    .reset_instr(reset_instr), .stack_full_reset(stack_full_reset),
    .stack_underflow_reset(stack_underflow_reset),
    .core_reset_hold(core_reset_hold), .core_wake_stall(core_wake_stall),
    .core_restart(core_restart), .sfr_init(sfr_init),
    .power_on_init(power_on_init), .reset_vector(reset_vector));
  supply_model supply_model_i (.core_clk(core_clk), .por_pulse(por_pulse),
    .brownout_detect(brownout_detect),
    .master_clear_pin_n(master_clear_pin_n), .osc_input_pin(osc_input_pin));
  function integer span(input [2:0] md, input pe);
    span = (pe ? PWT * RCD : 0) + (md < 3'h4 ? OSTC * OSP : 0) +
      ((md == 3'h3 || md == 3'h5) ? PLT * RCD : 0);
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk) penable <= 1'b1;
      // look mid-cycle so the answer is read before the edge takes it
      @(negedge core_clk);
      while (pready !== 1'b1) @(negedge core_clk);
      rd = prdata; err = pslverr;
      @(posedge core_clk);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task pulse(input integer s);
    begin
      case (s)
        0: watchdog_reset <= 1'b1;
        1: reset_instr <= 1'b1;
        2: stack_full_reset <= 1'b1;
        3: stack_underflow_reset <= 1'b1;
        4: int_wake <= 1'b1;
        default: watchdog_wake <= 1'b1;
      endcase
      @(posedge core_clk);
      {watchdog_reset, reset_instr, stack_full_reset, stack_underflow_reset,
        int_wake, watchdog_wake} <= 6'h0;
      // pulsed sources hold for one cycle only
      @(negedge core_clk);
      hs = core_reset_hold;
      @(posedge core_clk);
    end
  endtask
  // counts cycles until the given output drops, bounded
  task settle(input stall);
    begin
      n = 0;
      while ((stall ? core_wake_stall : core_reset_hold) !== 1'b0 &&
        n < 3000) begin
        n = n + 1;
        @(posedge core_clk);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge core_clk)
    if (sfr_init === 1'b1) sfr_n <= sfr_n + 1;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #300000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
  initial begin
    {srst, psel, penable, pwrite, sleep_mode, watchdog_reset} = 6'h20;
    {watchdog_wake, int_wake, reset_instr, stack_full_reset} = 4'h0;
    {stack_underflow_reset, paddr, pwdata} = 45'h0;
    {bad_count, comparisons, sfr_n} = 0;
    s0 = $urandom(32'h4eb1);
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    settle(0);
    apb(0, `REG_CONFIG, 0); check(rd, 32'h0b);
    apb(0, `REG_STATUS, 0); check(rd, 32'h1c);
    apb(0, 12'h00c, 0); check(err, 1'b1);
    check(rd, 32'h0);
    check(reset_vector, 16'h0000);
    // every oscillator mode, timer enable random, rc both ways
    for (i = 0; i < 8; i = i + 1) begin
      m = (i > 6) ? 3'h6 : i;
      p = (i == 6) ? 1'b0 : (i == 7) ? 1'b1 : $urandom_range(1);
      e = span(m, p);
      apb(1, `REG_CONFIG, {27'h0, m, 1'b1, p});
      apb(1, `REG_STATUS, 32'h3);
      supply_model_i.drive(0, 5 + $urandom_range(20));
      settle(0);
      check(n >= e - 6 && n <= e + 16, 1'b1);
      apb(0, `REG_STATUS, 0); check(rd, 32'h1c);
    end
    // recurring sag restarts the timer, no start-up count after
    apb(1, `REG_CONFIG, 32'h0b);
    supply_model_i.drive(1, 6);
    repeat (10) @(posedge core_clk);
    supply_model_i.drive(1, 6);
    settle(0);
    check(n >= PWT * RCD - 6 && n <= PWT * RCD + 8, 1'b1);
    apb(0, `REG_STATUS, 0); check(rd, 32'h1e);
    apb(1, `REG_CONFIG, 32'h09);
    supply_model_i.drive(1, 6);
    check(core_reset_hold, 0);
    supply_model_i.drive(2, 1 + $urandom_range(2));
    repeat (6) @(posedge core_clk);
    check(core_reset_hold, 0);
    supply_model_i.drive(2, 12);
    check(core_reset_hold, 1);
    fork
      supply_model_i.drive(2, 150);
      supply_model_i.drive(0, 10);
    join
    settle(0);
    check(n <= 8, 1'b1);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1, `REG_STATUS, 32'h1f);
      pulse(i);
      check(hs, 1);
      settle(0);
      apb(0, `REG_CAUSE, 0);
      check(rd[2:0], (i == 0) ? 3 : i + 4);
      apb(0, `REG_STATUS, 0);
      check(rd, (i == 0) ? 5'h17 : (i == 1) ? 5'h0f : 5'h1f);
    end
    // wakes from sleep in external clock mode: stall, no init
    apb(1, `REG_CONFIG, 32'h13);
    sleep_mode <= 1'b1;
    s0 = sfr_n;
    for (i = 4; i < 6; i = i + 1) begin
      apb(1, `REG_STATUS, 32'h1f);
      pulse(i);
      check(core_wake_stall, 1);
      settle(1);
      check(n >= 140 && n <= 156, 1'b1);
      apb(0, `REG_STATUS, 0);
      check(rd, (i == 4) ? 5'h1b : 5'h13);
    end
    sleep_mode <= 1'b0;
    check(sfr_n, s0);
    report_and_stop;
  end
endmodule // tb_top
